/* rtl/tcw_ctrl.sv */
// Critical warning, conversion scheduling and averaging control of a remote diode sensor
// Operation
// - Hysteresis field is byte 12 bits 4:0, weights 16..1 C, resets to 4 C.
// - A critical event sets status byte 14 bit 2 for the host.
// - Critical warning drives the active-low critical pin until the host clears it.
// - Writing one to byte 15 bit 7 releases the pin and clears status.
// - That same write also clears pending high and low threshold alert flags.
// - Byte 15 bit 6 picks standby or active; active converts at programmed rate.
// - In standby each host request yields one conversion, then the block idles.
// - Rate codes 0..4 give 16..1 per second, 5..10 one per 2..64 s.
// - Averaging count applies only while byte 15 bit 5 is set.
// - Byte 6 bits 1:0 select 1, 4, 8 or 16 averaged readings.
// - Critical warning when temperature exceeds 7-bit threshold, reset 127 C.
`timescale 1ns/1ps
`default_nettype none
`include "tcw_cfg.svh"

module tcw_ctrl #(
    parameter int unsigned TICK_CYCLES = `TCW_TICK_CYCLES // Clocks per 1/16 s base tick
) (
    input wire logic ref_clk, // 40 MHz device clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire tcw_pkg::tcw_byte_t regAddr, // Register byte index from serial slave
    input wire tcw_pkg::tcw_byte_t regWrData, // Write data byte
    input wire logic regWrEn, // One-cycle write strobe
    input wire logic regRdEn, // One-cycle read strobe
    output tcw_pkg::tcw_byte_t regRdData, // Read data, valid the cycle after regRdEn
    output logic adcStart, // Pulse: start one ADC reading
    input wire logic adcValid, // Pulse: ADC reading ready
    input wire tcw_pkg::tcw_temp_t adcData, // ADC reading, 0.125 C per LSB
    input wire logic hiAlertEvt, // Pulse from high threshold compare
    input wire logic loAlertEvt, // Pulse from low threshold compare
    output tcw_pkg::tcw_temp_t tempResult, // Latest averaged temperature
    output logic resultValid, // Pulse: tempResult updated
    output logic critOut_n // Critical temperature pin, active low
);
    import tcw_pkg::*;
    // Configuration and status registers
    tcw_byte_t avgCfg_reg, avgCfg_next, rdData_reg, rdData_next;
    logic [6:0] crit_reg, crit_next;
    logic [4:0] hys_reg, hys_next;
    logic [3:0] rate_reg, rate_next;
    logic maskBit_reg, maskBit_next, standby_reg, standby_next, avgEn_reg, avgEn_next;
    logic critStatus_reg, critStatus_next, hiFlag_reg, hiFlag_next, loFlag_reg, loFlag_next;
    logic critOutN_reg, critOutN_next, faultClr, hostReq;

    // Conversion scheduling and averaging state
    tcw_state_e state_reg, state_next;
    logic [21:0] tickCnt_reg, tickCnt_next;
    logic [10:0] periodCnt_reg, periodCnt_next, periodLen;
    logic [3:0] sampLeft_reg, sampLeft_next, rateEff, nMinus1;
    logic [14:0] acc_reg, acc_next;
    tcw_temp_t result_reg, result_next, avgVal;
    logic reqPend_reg, reqPend_next, resValid_reg, resValid_next, adcStart_reg, adcStart_next;
    logic armed_reg, armed_next, tick, convDue, startConv, critEvt;
    logic [2:0] shiftAmt;
    tcw_byte_t tempDeg, rearmLvl;

    // Slowest encoded rate covers every unlisted code; one reading when averaging is off
    always_comb begin
        rateEff = (rate_reg > `TCW_RATE_MAX) ? `TCW_RATE_MAX : rate_reg;
        periodLen = 11'h001 << rateEff;
        shiftAmt = 3'h0;
        if (avgEn_reg) begin
            case (avgCfg_reg[1:0])
                2'h1: shiftAmt = 3'h2;
                2'h2: shiftAmt = 3'h3;
                2'h3: shiftAmt = 3'h4;
                default: shiftAmt = 3'h0;
            endcase
        end
        // Count derived from the shift, so reading count and divide always agree
        nMinus1 = 4'((5'h01 << shiftAmt) - 5'h01);
    end

    // Register writes, sticky flags and the critical pin
    always_comb begin
        avgCfg_next = avgCfg_reg;
        crit_next = crit_reg;
        maskBit_next = maskBit_reg;
        hys_next = hys_reg;
        standby_next = standby_reg;
        avgEn_next = avgEn_reg;
        rate_next = rate_reg;
        faultClr = 1'b0;
        hostReq = 1'b0;
        if (regWrEn) begin
            if (regAddr == `TCW_OFS_AVG) begin
                avgCfg_next = regWrData;
            end else if (regAddr == `TCW_OFS_CRIT) begin
                crit_next = regWrData[6:0];
            end else if (regAddr == `TCW_OFS_MASKHYS) begin
                maskBit_next = regWrData[`TCW_MASK_BIT];
                hys_next = regWrData[4:0];
            end else if (regAddr == `TCW_OFS_CTRL) begin
                faultClr = regWrData[`TCW_CTRL_CLR];
                standby_next = regWrData[`TCW_CTRL_STBY];
                avgEn_next = regWrData[`TCW_CTRL_AVG];
                hostReq = regWrData[`TCW_CTRL_REQ];
            end else if (regAddr == `TCW_OFS_RATE) begin
                rate_next = regWrData[4:1];
            end
        end
        // A new event in the clearing cycle survives the clear
        critStatus_next = critEvt ? 1'b1 : (faultClr ? 1'b0 : critStatus_reg);
        hiFlag_next = hiAlertEvt ? 1'b1 : (faultClr ? 1'b0 : hiFlag_reg);
        loFlag_next = loAlertEvt ? 1'b1 : (faultClr ? 1'b0 : loFlag_reg);
        critOutN_next = ~critStatus_next;
        rdData_next = rdData_reg;
        if (regRdEn) begin
            if (regAddr == `TCW_OFS_AVG) begin
                rdData_next = avgCfg_reg;
            end else if (regAddr == `TCW_OFS_CRIT) begin
                rdData_next = {1'b0, crit_reg};
            end else if (regAddr == `TCW_OFS_MASKHYS) begin
                rdData_next = {maskBit_reg, 2'h0, hys_reg};
            end else if (regAddr == `TCW_OFS_STATUS) begin
                rdData_next = 8'h00;
                rdData_next[`TCW_STAT_HI] = hiFlag_reg;
                rdData_next[`TCW_STAT_LO] = loFlag_reg;
                rdData_next[`TCW_STAT_CRIT] = critStatus_reg;
            end else if (regAddr == `TCW_OFS_CTRL) begin
                rdData_next = {1'b0, standby_reg, avgEn_reg, 5'h00};
            end else if (regAddr == `TCW_OFS_RATE) begin
                rdData_next = {3'h0, rate_reg, 1'b0};
            end else begin
                rdData_next = 8'h00;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avgCfg_reg <= `TCW_RST_AVG;
            crit_reg <= `TCW_RST_CRIT;
            maskBit_reg <= 1'b0;
            hys_reg <= `TCW_RST_HYS;
            standby_reg <= 1'b0;
            avgEn_reg <= 1'b0;
            rate_reg <= `TCW_RST_RATE;
            critStatus_reg <= 1'b0;
            hiFlag_reg <= 1'b0;
            loFlag_reg <= 1'b0;
            critOutN_reg <= 1'b1;
            rdData_reg <= 8'h00;
        end else begin
            avgCfg_reg <= avgCfg_next;
            crit_reg <= crit_next;
            maskBit_reg <= maskBit_next;
            hys_reg <= hys_next;
            standby_reg <= standby_next;
            avgEn_reg <= avgEn_next;
            rate_reg <= rate_next;
            critStatus_reg <= critStatus_next;
            hiFlag_reg <= hiFlag_next;
            loFlag_reg <= loFlag_next;
            critOutN_reg <= critOutN_next;
            rdData_reg <= rdData_next;
        end
    end

    // Rate timer, request latch, conversion sequencer and critical compare
    always_comb begin
        tick = (tickCnt_reg == 22'(TICK_CYCLES - 1));
        tickCnt_next = tick ? 22'h000000 : tickCnt_reg + 22'h000001;
        convDue = 1'b0;
        periodCnt_next = periodCnt_reg;
        if (standby_reg || (rate_next != rate_reg)) begin // A new rate restarts the period
            periodCnt_next = 11'h000;
        end else if (tick) begin
            convDue = (periodCnt_reg >= periodLen - 11'h001);
            periodCnt_next = convDue ? 11'h000 : periodCnt_reg + 11'h001;
        end
        startConv = (state_reg == TCW_IDLE) && (standby_reg ? reqPend_reg : convDue);
        reqPend_next = hostReq ? 1'b1 : (startConv ? 1'b0 : reqPend_reg);
        avgVal = tcw_temp_t'(acc_reg >> shiftAmt);
        tempDeg = avgVal[10:3];
        rearmLvl = ({1'b0, crit_reg} >= {3'h0, hys_reg}) ?
            ({1'b0, crit_reg} - {3'h0, hys_reg}) : 8'h00;
        critEvt = (state_reg == TCW_DONE) && armed_reg && (tempDeg > {1'b0, crit_reg});
        armed_next = armed_reg;
        if (critEvt) begin
            armed_next = 1'b0;
        end else if ((state_reg == TCW_DONE) && (tempDeg < rearmLvl)) begin
            armed_next = 1'b1;
        end
        state_next = state_reg;
        sampLeft_next = sampLeft_reg;
        acc_next = acc_reg;
        result_next = result_reg;
        resValid_next = 1'b0;
        adcStart_next = 1'b0;
        case (state_reg)
            TCW_IDLE: begin
                if (startConv) begin
                    adcStart_next = 1'b1;
                    sampLeft_next = nMinus1;
                    acc_next = 15'h0000;
                    state_next = TCW_SAMPLE;
                end
            end
            TCW_SAMPLE: begin
                if (adcValid) begin
                    acc_next = acc_reg + {4'h0, adcData};
                    if (sampLeft_reg == 4'h0) begin
                        state_next = TCW_DONE;
                    end else begin
                        sampLeft_next = sampLeft_reg - 4'h1;
                        adcStart_next = 1'b1;
                    end
                end
            end
            TCW_DONE: begin
                result_next = avgVal;
                resValid_next = 1'b1;
                state_next = TCW_IDLE;
            end
            default: state_next = TCW_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_reg <= TCW_IDLE;
            tickCnt_reg <= 22'h000000;
            periodCnt_reg <= 11'h000;
            reqPend_reg <= 1'b0;
            sampLeft_reg <= 4'h0;
            acc_reg <= 15'h0000;
            result_reg <= 11'h000;
            resValid_reg <= 1'b0;
            adcStart_reg <= 1'b0;
            armed_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            tickCnt_reg <= tickCnt_next;
            periodCnt_reg <= periodCnt_next;
            reqPend_reg <= reqPend_next;
            sampLeft_reg <= sampLeft_next;
            acc_reg <= acc_next;
            result_reg <= result_next;
            resValid_reg <= resValid_next;
            adcStart_reg <= adcStart_next;
            armed_reg <= armed_next;
        end
    end
    // Every output comes straight from a flop
    assign regRdData = rdData_reg;
    assign adcStart = adcStart_reg;
    assign tempResult = result_reg;
    assign resultValid = resValid_reg;
    assign critOut_n = critOutN_reg;
    // Checks on the warning path and the conversion sequencer
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence convFinish;
        state_reg == TCW_DONE ##1 (state_reg == TCW_IDLE && resValid_reg);
    endsequence
    sequence pinRelease;
        !critStatus_reg && critOutN_reg;
    endsequence
    hys_reset_a: assert property ($rose(rst_n) |-> hys_reg == `TCW_RST_HYS)
        else $error("hysteresis not at reset value");
    crit_status_set_a: assert property (critEvt |=> critStatus_reg && !critOutN_reg)
        else $error("critical status or pin missed an event");
    crit_pin_hold_a: assert property (critStatus_reg && !faultClr |=> !critOutN_reg)
        else $error("critical pin released without a clear");
    fault_clear_a: assert property (faultClr && !critEvt |=> pinRelease)
        else $error("fault clear did not release the pin");
    alert_clear_a: assert property (faultClr && !hiAlertEvt && !loAlertEvt
        |=> !hiFlag_reg && !loFlag_reg)
        else $error("fault clear left an alert flag");
    active_start_a: assert property (convDue && state_reg == TCW_IDLE |=> adcStart_reg)
        else $error("due conversion not started");
    standby_idle_a: assert property (standby_reg && !reqPend_reg && state_reg == TCW_IDLE
        |=> !adcStart_reg)
        else $error("standby conversion without request");
    one_shot_a: assert property (state_reg == TCW_DONE |-> convFinish)
        else $error("conversion did not return to idle");
    rate_due_a: assert property (convDue |-> periodCnt_reg == periodLen - 11'h001)
        else $error("conversion due at wrong period");
    avg_off_a: assert property (!avgEn_reg && startConv |=> sampLeft_reg == 4'h0)
        else $error("averaging applied while disabled");
    avg_sixteen_a: assert property (avgEn_reg && avgCfg_reg[1:0] == 2'h3 && startConv
        |=> sampLeft_reg == 4'hF)
        else $error("wrong reading count for sixteen");
    crit_thresh_a: assert property (critEvt |=> result_reg[10:3] > {1'b0, crit_reg})
        else $error("critical event below threshold");
    hys_rearm_a: assert property ($rose(critStatus_reg) |-> $past(armed_reg))
        else $error("critical event while disarmed");
    rate_clamp_a: assert property (rate_reg > `TCW_RATE_MAX
        |-> periodLen == (11'h001 << `TCW_RATE_MAX))
        else $error("unlisted rate code not clamped");
endmodule // tcw_ctrl
`default_nettype wire

/* include/tcw_cfg.svh */
// Register offsets, field positions, reset values and timing for the thermal warning block
`ifndef TCW_CFG_SVH
`define TCW_CFG_SVH
`define TCW_OFS_AVG 8'h06
`define TCW_OFS_CRIT 8'h07
`define TCW_OFS_MASKHYS 8'h0C
`define TCW_OFS_STATUS 8'h0E
`define TCW_OFS_CTRL 8'h0F
`define TCW_OFS_RATE 8'h11
`define TCW_RST_AVG 8'h00
`define TCW_RST_CRIT 7'h7F
`define TCW_RST_HYS 5'h04
`define TCW_RST_RATE 4'h2
`define TCW_RATE_MAX 4'hA
`define TCW_CTRL_CLR 7
`define TCW_CTRL_STBY 6
`define TCW_CTRL_AVG 5
`define TCW_CTRL_REQ 4
`define TCW_MASK_BIT 7
`define TCW_STAT_HI 6
`define TCW_STAT_LO 5
`define TCW_STAT_CRIT 2
// Base tick is the fastest conversion period, 1/16 s, in nanoseconds
`define TCW_TICK_NS 62500000
`define TCW_CLK_NS 25
`define TCW_TICK_CYCLES (`TCW_TICK_NS / `TCW_CLK_NS)
`endif

/* include/tcw_pkg.sv */
// Types shared by the thermal warning and conversion control block
`default_nettype none
package tcw_pkg;
    typedef enum logic [2:0] {
        TCW_IDLE = 3'b001,
        TCW_SAMPLE = 3'b010,
        TCW_DONE = 3'b100
    } tcw_state_e;
    typedef logic [7:0] tcw_byte_t;
    typedef logic [10:0] tcw_temp_t;
endpackage
`default_nettype wire

/* dv/tcw_adc_model.sv */
// Behavioural ADC that answers each start pulse with one reading
`timescale 1ns/1ps
`default_nettype none
module tcw_adc_model (
    input wire logic ref_clk, // Device clock
    input wire logic adcStart, // Start pulse from the block
    input wire logic slow, // Longer, varying answer delay when high
    input wire tcw_pkg::tcw_temp_t tempIn, // Reading to hand back
    output logic adcValid, // One-cycle ready pulse
    output tcw_pkg::tcw_temp_t adcData // Reading, scrambled while idle
);
    import tcw_pkg::*;
    int unsigned waitN;
    // Idle data toggles every cycle so a stale reading never looks valid
    initial begin
        adcValid = 1'b0;
        adcData = 11'h000;
        forever begin
            @(posedge ref_clk);
            adcData <= ~adcData;
            if (adcStart) begin
                waitN = slow ? 1 + (tempIn % 5) : 1;
                repeat (waitN) @(posedge ref_clk);
                adcValid <= 1'b1;
                adcData <= tempIn;
                @(posedge ref_clk);
                adcValid <= 1'b0;
                adcData <= ~tempIn;
            end
        end
    end
endmodule // tcw_adc_model
`default_nettype wire

/* dv/thermal_critical_warn_conv_ctrl_test.sv */
// Self-checking bench for the critical warning and conversion control block
`timescale 1ns/1ps
`default_nettype none
`include "tcw_cfg.svh"
module thermal_critical_warn_conv_ctrl_test;
    import tcw_pkg::*;
    localparam int unsigned TICK = 8; // Shortened base tick keeps slow rates short
    typedef struct {logic [7:0] n; tcw_temp_t t;} tcw_exp_s;
    logic ref_clk, rst_n, regWrEn, regRdEn, adcValid, hiAlertEvt, loAlertEvt;
    logic adcStart, resultValid, critOut_n, slow, chkOn, rdPend;
    tcw_byte_t regAddr, regWrData, regRdData;
    tcw_temp_t adcData, tempResult, tempIn;
    tcw_byte_t rdQ[$];
    tcw_exp_s cvQ[$];
    tcw_exp_s e;
    int unsigned failCount, nCompared, startCnt, i, n;
    int unsigned degs[5] = '{60, 46, 60, 45, 60};
    logic pins[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    int unsigned codes[5] = '{0, 3, 4, 10, 15};
    logic [7:0] avgN[4] = '{8'h01, 8'h04, 8'h08, 8'h10};

    tcw_ctrl #(.TICK_CYCLES(TICK)) tcw_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
        .regRdData(regRdData), .adcStart(adcStart), .adcValid(adcValid), .adcData(adcData),
        .hiAlertEvt(hiAlertEvt), .loAlertEvt(loAlertEvt), .tempResult(tempResult),
        .resultValid(resultValid), .critOut_n(critOut_n));
    tcw_adc_model tcw_adc_model_inst (.ref_clk(ref_clk), .adcStart(adcStart), .slow(slow),
        .tempIn(tempIn), .adcValid(adcValid), .adcData(adcData));

    // 40 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic testDone();
        $display("Counts: %0d compared, %0d mismatched", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wr(input tcw_byte_t a, input tcw_byte_t d);
        @(posedge ref_clk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
    endtask

    // Expected read byte is noted before the strobe goes out
    task automatic rd(input tcw_byte_t a, input tcw_byte_t d);
        @(posedge ref_clk);
        rdQ.push_back(d);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
    endtask

    // One host-requested conversion; afterwards the converter must stay quiet
    task automatic conv(input tcw_byte_t ctl, input logic [7:0] cnt, input tcw_temp_t t);
        int unsigned k;
        tempIn <= t;
        cvQ.push_back('{cnt, t});
        wr(`TCW_OFS_CTRL, ctl | 8'h10);
        k = 0;
        do begin @(posedge ref_clk); k++; end while (resultValid !== 1'b1 && k < 400);
        if (k >= 400) chk(1'b0, 1'b1, "no result");
        repeat (40) @(posedge ref_clk);
        chk(startCnt, 0, "idle starts");
    endtask

    task automatic waitStart();
        int unsigned k;
        k = 0;
        do begin @(posedge ref_clk); k++; end while (adcStart !== 1'b1 && k < 20000);
    endtask

    // Monitor: reads and conversion results are matched against the oldest note
    always @(posedge ref_clk) begin
        if (rdPend && rdQ.size() > 0) chk({24'h0, regRdData}, rdQ.pop_front(), "read");
        rdPend <= regRdEn;
        if (adcStart === 1'b1) startCnt++;
        if (resultValid === 1'b1) begin
            if (chkOn && cvQ.size() > 0) begin
                e = cvQ.pop_front();
                chk({21'h0, tempResult}, {21'h0, e.t}, "result");
                chk(startCnt, e.n, "readings");
            end
            startCnt = 0;
        end
    end

    // Watchdog: the slow rate codes dominate, about 50k cycles; stay under 90k in all
    initial begin
        #(25ns * 90000);
        failCount++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        testDone();
    end

    initial begin
        {rst_n, regWrEn, regRdEn, hiAlertEvt, loAlertEvt, slow, chkOn, rdPend} = '0;
        {regAddr, regWrData, failCount, nCompared, startCnt} = '0;
        tempIn = 11'd200;
        void'($urandom(32'h5FE8B2C6));
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`TCW_OFS_AVG, 8'h00);
        rd(`TCW_OFS_CRIT, 8'h7F);
        rd(`TCW_OFS_MASKHYS, 8'h04);
        rd(`TCW_OFS_STATUS, 8'h00);
        rd(`TCW_OFS_CTRL, 8'h00);
        rd(`TCW_OFS_RATE, 8'h04);
        rd(8'h20, 8'h00);
        wr(`TCW_OFS_MASKHYS, 8'h9F);
        rd(`TCW_OFS_MASKHYS, 8'h9F);
        wr(`TCW_OFS_MASKHYS, 8'h04);
        wr(`TCW_OFS_STATUS, 8'hFF);
        rd(`TCW_OFS_STATUS, 8'h00);
        $display("Registers test done");
        // Standby with averaging off, then each averaging count
        wr(`TCW_OFS_CTRL, 8'h40);
        repeat (60) @(posedge ref_clk);
        #1 startCnt = 0;
        chkOn = 1'b1;
        slow = 1'b1;
        wr(`TCW_OFS_AVG, 8'h03);
        conv(8'h40, 8'h01, 11'($urandom_range(0, 1000)));
        for (i = 0; i < 4; i++) begin
            wr(`TCW_OFS_AVG, 8'(i));
            conv(8'h60, avgN[i], 11'($urandom_range(0, 1000)));
        end
        $display("Averaging test done");
        // Critical event, sticky status, clear and hysteresis rearm
        wr(`TCW_OFS_CRIT, 8'h32);
        conv(8'h40, 8'h01, 11'(60 * 8));
        chk(critOut_n, 1'b0, "pin set");
        rd(`TCW_OFS_STATUS, 8'h04);
        @(posedge ref_clk);
        hiAlertEvt <= 1'b1;
        loAlertEvt <= 1'b1;
        @(posedge ref_clk);
        hiAlertEvt <= 1'b0;
        loAlertEvt <= 1'b0;
        rd(`TCW_OFS_STATUS, 8'h64);
        chk(critOut_n, 1'b0, "pin held");
        wr(`TCW_OFS_CTRL, 8'hC0);
        #1 chk(critOut_n, 1'b1, "pin clear");
        rd(`TCW_OFS_STATUS, 8'h00);
        for (i = 0; i < 5; i++) begin
            conv(8'h40, 8'h01, 11'(degs[i] * 8));
            chk(critOut_n, pins[i], "rearm");
        end
        $display("Critical test done");
        // Active mode conversion period for rate codes 0, 3, 4, 10 and unlisted 15
        chkOn = 1'b0;
        slow = 1'b0;
        tempIn <= 11'd200;
        wr(`TCW_OFS_CTRL, 8'h00);
        for (i = 0; i < 5; i++) begin
            wr(`TCW_OFS_RATE, {3'h0, 4'(codes[i]), 1'b0});
            if (codes[i] <= 10) rd(`TCW_OFS_RATE, {3'h0, 4'(codes[i]), 1'b0});
            waitStart();
            waitStart();
            n = 0;
            do begin @(posedge ref_clk); n++; end while (adcStart !== 1'b1 && n < 20000);
            chk(n, (1 << (codes[i] > 10 ? 10 : codes[i])) * TICK, "period");
        end
        $display("Rate test done");
        testDone();
    end
endmodule // thermal_critical_warn_conv_ctrl_test
`default_nettype wire
